// ### rtl/udc_map.svh
// udc_map.svh: register offsets, field positions and reset values of the up/down counter
// assumes byte addresses on an ahb-lite bus with 32-bit data, decoded on the low 8 bits
`ifndef UDC_MAP_SVH
`define UDC_MAP_SVH
`define UDC_OFF_CTRL 8'h00
`define UDC_OFF_START 8'h04
`define UDC_OFF_NEW_A 8'h08
`define UDC_OFF_NEW_B 8'h0C
`define UDC_OFF_ACT 8'h10
`define UDC_OFF_COUNT 8'h14
`define UDC_OFF_CMP_A 8'h18
`define UDC_OFF_CMP_B 8'h1C
`define UDC_OFF_IMAGE 8'h20
`define UDC_OFF_STATUS 8'h24
`define UDC_OFF_IRQ_STAT 8'h28
`define UDC_OFF_IRQ_MASK 8'h2C
`define UDC_CTRL_CNT_EN 0
`define UDC_CTRL_OUT_EN 1
`define UDC_CTRL_AUTO_UPD 2
`define UDC_CTRL_UP_EN 3
`define UDC_CTRL_DN_EN 4
`define UDC_CTRL_LD_START 5
`define UDC_CTRL_LD_A 6
`define UDC_CTRL_LD_B 7
`define UDC_CTRL_RST 32'h00000018
`define UDC_ACT_STRIDE 8
`define UDC_ACT_W 5
`define UDC_WORD_RST 32'h00000000
`endif

// ### rtl/udc_pkg.sv
// udc_pkg: types of the up/down counter with two comparators
// assumes udc_map.svh carries every offset, the control bit positions and the action stride
package udc_pkg;
   typedef enum logic [1:0] {UDC_OUT_NONE = 2'b00, UDC_OUT_OFF = 2'b01, UDC_OUT_ON = 2'b10} udc_out_act_type;
   typedef enum logic [1:0] {UDC_BUS_IDLE = 2'b00, UDC_BUS_WR = 2'b01, UDC_BUS_RD = 2'b10} udc_bus_st_type;
   typedef struct packed {
      logic set_cmp;
      logic reset_cnt;
      logic irq_en;
      udc_out_act_type out_act;
   } udc_act_type;
   typedef struct packed {
      logic up;
      logic down;
      logic dir;
      logic hw_run;
      logic cycle_point;
   } udc_field_in_type;
   typedef struct packed {
      udc_bus_st_type bus;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] start_val;
      logic [31:0] new_a;
      logic [31:0] new_b;
      logic [31:0] act;
      logic [31:0] count;
      logic [31:0] cmp_a;
      logic [31:0] cmp_b;
      logic [31:0] image;
      logic [3:0] ist;
      logic [3:0] imask;
      logic up_prev;
      logic dn_prev;
      logic [2:0] ld_prev;
      logic dout_a;
      logic dout_b;
   } udc_state_type;
endpackage

// ### rtl/udc_top.sv
// udc_top: up/down event counter, two comparators, event actions, ahb-lite register slave
// assumes field inputs already synchronous to hclk, one ahb-lite master, word transfers only
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "udc_map.svh"
// Summary of operation
// - up input rising edge adds one
// - down input rising edge subtracts one
// - direction high keeps up/down sense normal
// - hardware start/stop low freezes the count
// - each input counts only when edge-enabled
// - comparator A reached from just below
// - comparator A fell to one below
// - comparator B has both same events
// - reach of A may clear output A
// - fall below A may set output A
// - output B may be set on fall, cleared on reach
// - event raises interrupt only when enabled
// - event reloads start value only when enabled
// - event adopts new compare only when enabled
// - auto update copies count at cycle point
// - loads happen on request rising edge only
// - outputs follow events only while enabled
// - status A drops once count below A
module udc_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // field side
   input udc_pkg::udc_field_in_type field_in,
   output logic dout_a,
   output logic dout_b,
   output logic irq
);

   udc_pkg::udc_state_type st_reg;
   udc_pkg::udc_state_type st_next;
   udc_pkg::udc_act_type act_f [4];
   logic up_rise;
   logic dn_rise;
   logic inc;
   logic dec;
   logic run;
   logic [31:0] cnt_step;
   logic [3:0] ev;
   logic [3:0] ev_rst;
   logic [2:0] ld_rise;
   logic stat_a;
   logic stat_b;
   logic addr_take;
   logic [31:0] rd_mux;

   // edge detection against the previous sample
   assign up_rise = field_in.up & ~st_reg.up_prev & st_reg.ctrl[`UDC_CTRL_UP_EN];
   assign dn_rise = field_in.down & ~st_reg.dn_prev & st_reg.ctrl[`UDC_CTRL_DN_EN];
   // low direction swaps the sense of the two inputs
   assign inc = field_in.dir ? up_rise : dn_rise;
   assign dec = field_in.dir ? dn_rise : up_rise;
   assign run = st_reg.ctrl[`UDC_CTRL_CNT_EN] & field_in.hw_run;
   // simultaneous up and down edges cancel out
   always_comb begin
      cnt_step = st_reg.count;
      if (run && inc && !dec) begin
         cnt_step = st_reg.count + 32'h00000001;
      end else if (run && dec && !inc) begin
         cnt_step = st_reg.count - 32'h00000001;
      end
   end

   // events 0/1 belong to comparator A, 2/3 to B; even index is reach, odd is fall
   for (genvar i = 0; i < 4; i++) begin : g_ev
      logic [31:0] cv;
      assign cv = (i < 2) ? st_reg.cmp_a : st_reg.cmp_b;
      assign act_f[i] = udc_pkg::udc_act_type'(st_reg.act[i*`UDC_ACT_STRIDE +: `UDC_ACT_W]);
      if (i % 2 == 0) begin : g_reach
         assign ev[i] = (st_reg.count == cv - 32'h00000001) && (cnt_step == cv);
      end else begin : g_fall
         assign ev[i] = (st_reg.count == cv) && (cnt_step == cv - 32'h00000001);
      end
      assign ev_rst[i] = ev[i] & act_f[i].reset_cnt;
   end

   // software must drop a request bit before raising it again
   assign ld_rise = st_reg.ctrl[`UDC_CTRL_LD_B:`UDC_CTRL_LD_START] & ~st_reg.ld_prev;
   assign stat_a = st_reg.count >= st_reg.cmp_a;
   assign stat_b = st_reg.count >= st_reg.cmp_b;
   assign addr_take = hsel & hready & htrans[1];

   always_comb begin
      case (haddr[7:0])
         `UDC_OFF_CTRL: rd_mux = st_reg.ctrl;
         `UDC_OFF_START: rd_mux = st_reg.start_val;
         `UDC_OFF_NEW_A: rd_mux = st_reg.new_a;
         `UDC_OFF_NEW_B: rd_mux = st_reg.new_b;
         `UDC_OFF_ACT: rd_mux = st_reg.act;
         `UDC_OFF_COUNT: rd_mux = st_reg.count;
         `UDC_OFF_CMP_A: rd_mux = st_reg.cmp_a;
         `UDC_OFF_CMP_B: rd_mux = st_reg.cmp_b;
         `UDC_OFF_IMAGE: rd_mux = st_reg.image;
         `UDC_OFF_STATUS: rd_mux = {28'h0000000, st_reg.dout_b, st_reg.dout_a, stat_b, stat_a};
         `UDC_OFF_IRQ_STAT: rd_mux = {28'h0000000, st_reg.ist};
         `UDC_OFF_IRQ_MASK: rd_mux = {28'h0000000, st_reg.imask};
         default: rd_mux = `UDC_WORD_RST;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      // bus data phase first, so hardware effects below override it
      case (st_reg.bus)
         udc_pkg::UDC_BUS_WR: begin
            case (st_reg.addr)
               `UDC_OFF_CTRL: st_next.ctrl = hwdata;
               `UDC_OFF_START: st_next.start_val = hwdata;
               `UDC_OFF_NEW_A: st_next.new_a = hwdata;
               `UDC_OFF_NEW_B: st_next.new_b = hwdata;
               `UDC_OFF_ACT: st_next.act = hwdata;
               `UDC_OFF_IRQ_STAT: st_next.ist = st_reg.ist & ~hwdata[3:0];
               `UDC_OFF_IRQ_MASK: st_next.imask = hwdata[3:0];
               default: st_next.ist = st_next.ist;
            endcase
         end
         default: st_next.bus = udc_pkg::UDC_BUS_IDLE;
      endcase
      if (addr_take) begin
         st_next.bus = hwrite ? udc_pkg::UDC_BUS_WR : udc_pkg::UDC_BUS_RD;
         st_next.addr = haddr[7:0];
         if (!hwrite) begin
            st_next.rdata = rd_mux;
         end
      end else begin
         st_next.bus = udc_pkg::UDC_BUS_IDLE;
      end
      st_next.up_prev = field_in.up;
      st_next.dn_prev = field_in.down;
      st_next.ld_prev = st_reg.ctrl[`UDC_CTRL_LD_B:`UDC_CTRL_LD_START];
      st_next.count = cnt_step;
      if (ld_rise[0]) begin
         st_next.count = st_reg.start_val;
      end
      if (ld_rise[1]) begin
         st_next.cmp_a = st_reg.new_a;
      end
      if (ld_rise[2]) begin
         st_next.cmp_b = st_reg.new_b;
      end
      for (int i = 0; i < 4; i++) begin
         if (ev[i]) begin
            // set wins over a clearing write in the same cycle
            if (act_f[i].irq_en) begin
               st_next.ist[i] = 1'b1;
            end
            if (act_f[i].reset_cnt) begin
               st_next.count = st_reg.start_val;
            end
            if (act_f[i].set_cmp) begin
               if (i < 2) begin
                  st_next.cmp_a = st_reg.new_a;
               end else begin
                  st_next.cmp_b = st_reg.new_b;
               end
            end
            if (st_reg.ctrl[`UDC_CTRL_OUT_EN] && act_f[i].out_act != udc_pkg::UDC_OUT_NONE) begin
               if (i < 2) begin
                  st_next.dout_a = (act_f[i].out_act == udc_pkg::UDC_OUT_ON);
               end else begin
                  st_next.dout_b = (act_f[i].out_act == udc_pkg::UDC_OUT_ON);
               end
            end
         end
      end
      // image lags the live count by design: it is the value seen at the cycle point
      if (st_reg.ctrl[`UDC_CTRL_AUTO_UPD] && field_in.cycle_point) begin
         st_next.image = st_reg.count;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.bus <= udc_pkg::UDC_BUS_IDLE;
         st_reg.ctrl <= `UDC_CTRL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign dout_a = st_reg.dout_a;
   assign dout_b = st_reg.dout_b;
   assign irq = |(st_reg.ist & st_reg.imask);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   up_count_a: assert property ((run && inc && !dec && ev_rst == 4'h0 && !ld_rise[0])
      |=> st_reg.count == $past(st_reg.count) + 32'h00000001)
      else $error("count did not step up");
   down_count_a: assert property ((run && dec && !inc && ev_rst == 4'h0 && !ld_rise[0])
      |=> st_reg.count == $past(st_reg.count) - 32'h00000001)
      else $error("count did not step down");
   dir_sense_a: assert property ((field_in.dir && up_rise && !dn_rise && run && ev_rst == 4'h0 && !ld_rise[0])
      |=> st_reg.count == $past(st_reg.count) + 32'h00000001)
      else $error("direction sense wrong");
   stop_hold_a: assert property ((!field_in.hw_run && !ld_rise[0]) |=> $stable(st_reg.count))
      else $error("count moved while stopped");
   edge_gate_a: assert property ((!st_reg.ctrl[`UDC_CTRL_UP_EN] && !st_reg.ctrl[`UDC_CTRL_DN_EN] && !ld_rise[0])
      |=> $stable(st_reg.count))
      else $error("count moved with edges disabled");
   reach_a_out_a: assert property ((ev[0] && st_reg.ctrl[`UDC_CTRL_OUT_EN] && !ev[1]
      && act_f[0].out_act == udc_pkg::UDC_OUT_OFF) |=> !dout_a)
      else $error("output A not cleared on reach");
   fall_a_out_a: assert property ((st_reg.count == st_reg.cmp_a && cnt_step == st_reg.cmp_a - 32'h00000001
      && st_reg.ctrl[`UDC_CTRL_OUT_EN] && act_f[1].out_act == udc_pkg::UDC_OUT_ON) |=> dout_a)
      else $error("output A not set on fall");
   out_gate_a: assert property (!st_reg.ctrl[`UDC_CTRL_OUT_EN] |=> $stable(dout_a) && $stable(dout_b))
      else $error("output moved while disabled");
   irq_gate_a: assert property ($rose(st_reg.ist[2]) |-> $past(ev[2] && act_f[2].irq_en))
      else $error("interrupt without enabled event");
   cmp_load_a: assert property ($changed(st_reg.cmp_b) |-> $past(ld_rise[2]
      || (ev[2] && act_f[2].set_cmp) || (ev[3] && act_f[3].set_cmp)))
      else $error("compare B changed without cause");
   image_upd_a: assert property ((st_reg.ctrl[`UDC_CTRL_AUTO_UPD] && field_in.cycle_point)
      |=> st_reg.image == $past(st_reg.count))
      else $error("image not refreshed");
   reset_cnt_a: assert property ((|ev_rst) |=> st_reg.count == $past(st_reg.start_val))
      else $error("counter not reloaded");
   status_a_a: assert property ((st_reg.count < st_reg.cmp_a) |-> ##1 (st_reg.count >= st_reg.cmp_a || !stat_a))
      else $error("status A stuck above");

   // bus side: zero wait states, okay answers, read word stands until the next read
   ready_high_a: assert property (hreadyout)
      else $error("slave inserted a wait state");
   resp_okay_a: assert property (!hresp)
      else $error("slave answered with an error");
   rdata_load_a: assert property ((addr_take && !hwrite)
      |=> hrdata == $past(rd_mux))
      else $error("read data not captured at address edge");
   rdata_hold_a: assert property (!(addr_take && !hwrite)
      |=> $stable(hrdata))
      else $error("read data moved without a read");
   rd_unmapped_a: assert property ((addr_take && !hwrite
      && haddr[7:0] > `UDC_OFF_IRQ_MASK)
      |=> hrdata == `UDC_WORD_RST)
      else $error("unmapped read not zero");
   bus_wr_a: assert property ((addr_take && hwrite)
      |=> st_reg.bus == udc_pkg::UDC_BUS_WR)
      else $error("write address phase not taken");
   bus_rd_a: assert property ((addr_take && !hwrite)
      |=> st_reg.bus == udc_pkg::UDC_BUS_RD)
      else $error("read address phase not taken");
   bus_idle_a: assert property (!addr_take
      |=> st_reg.bus == udc_pkg::UDC_BUS_IDLE)
      else $error("data phase without address phase");

   // register writes land at the edge that ends the data phase
   wr_ctrl_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_CTRL)
      |=> st_reg.ctrl == $past(hwdata))
      else $error("control write lost");
   wr_start_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_START)
      |=> st_reg.start_val == $past(hwdata))
      else $error("start value write lost");
   wr_new_a_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_NEW_A)
      |=> st_reg.new_a == $past(hwdata))
      else $error("pending compare A write lost");
   wr_new_b_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_NEW_B)
      |=> st_reg.new_b == $past(hwdata))
      else $error("pending compare B write lost");
   wr_act_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_ACT)
      |=> st_reg.act == $past(hwdata))
      else $error("action write lost");
   wr_mask_a: assert property ((st_reg.bus == udc_pkg::UDC_BUS_WR
      && st_reg.addr == `UDC_OFF_IRQ_MASK)
      |=> st_reg.imask == $past(hwdata[3:0]))
      else $error("mask write lost");

   // counting sense, gating and cancellation
   dir_low_up_a: assert property ((!field_in.dir && up_rise && !dn_rise && run
      && ev_rst == 4'h0 && !ld_rise[0])
      |=> st_reg.count == $past(st_reg.count) - 32'h00000001)
      else $error("swapped up input did not step down");
   dir_low_dn_a: assert property ((!field_in.dir && dn_rise && !up_rise && run
      && ev_rst == 4'h0 && !ld_rise[0])
      |=> st_reg.count == $past(st_reg.count) + 32'h00000001)
      else $error("swapped down input did not step up");
   both_edges_a: assert property ((up_rise && dn_rise && !ld_rise[0])
      |=> $stable(st_reg.count))
      else $error("opposite edges did not cancel");
   cnt_off_a: assert property ((!st_reg.ctrl[`UDC_CTRL_CNT_EN] && !ld_rise[0])
      |=> $stable(st_reg.count))
      else $error("count moved while disabled");
   prev_track_a: assert property (1'b1
      |=> st_reg.up_prev == $past(field_in.up) && st_reg.dn_prev == $past(field_in.down))
      else $error("edge history not tracked");

   // loads on request edges only; a held request does nothing more
   ld_start_a: assert property (ld_rise[0]
      |=> st_reg.count == $past(st_reg.start_val))
      else $error("start value not loaded");
   ld_held_a: assert property ((st_reg.ctrl[`UDC_CTRL_LD_START] && st_reg.ld_prev[0] && !run)
      |=> $stable(st_reg.count))
      else $error("held request reloaded the count");
   ld_cmp_a_a: assert property (ld_rise[1]
      |=> st_reg.cmp_a == $past(st_reg.new_a))
      else $error("compare A not loaded");
   ld_cmp_b_a: assert property (ld_rise[2]
      |=> st_reg.cmp_b == $past(st_reg.new_b))
      else $error("compare B not loaded");
   cmp_a_cause_a: assert property ($changed(st_reg.cmp_a) |-> $past(ld_rise[1]
      || (ev[0] && act_f[0].set_cmp) || (ev[1] && act_f[1].set_cmp)))
      else $error("compare A changed without cause");
   cmp_a_set_a: assert property (((ev[0] && act_f[0].set_cmp) || (ev[1] && act_f[1].set_cmp))
      |=> st_reg.cmp_a == $past(st_reg.new_a))
      else $error("compare A not adopted on event");
   cmp_b_set_a: assert property (((ev[2] && act_f[2].set_cmp) || (ev[3] && act_f[3].set_cmp))
      |=> st_reg.cmp_b == $past(st_reg.new_b))
      else $error("compare B not adopted on event");

   // outputs move only on their own comparator's events
   out_b_fall_a: assert property ((ev[3] && st_reg.ctrl[`UDC_CTRL_OUT_EN]
      && act_f[3].out_act == udc_pkg::UDC_OUT_ON)
      |=> dout_b)
      else $error("output B not set on fall");
   out_b_reach_a: assert property ((ev[2] && st_reg.ctrl[`UDC_CTRL_OUT_EN]
      && act_f[2].out_act == udc_pkg::UDC_OUT_OFF)
      |=> !dout_b)
      else $error("output B not cleared on reach");
   out_a_idle_a: assert property ((!ev[0] && !ev[1])
      |=> $stable(dout_a))
      else $error("output A moved without event");
   out_b_idle_a: assert property ((!ev[2] && !ev[3])
      |=> $stable(dout_b))
      else $error("output B moved without event");
   image_hold_a: assert property (!(st_reg.ctrl[`UDC_CTRL_AUTO_UPD] && field_in.cycle_point)
      |=> $stable(st_reg.image))
      else $error("image moved off the cycle point");

   // sticky flags: set wins over a clearing write in the same cycle
   for (genvar i = 0; i < 4; i++) begin : g_ist_chk
      logic w1c;
      assign w1c = (st_reg.bus == udc_pkg::UDC_BUS_WR) && (st_reg.addr == `UDC_OFF_IRQ_STAT) && hwdata[i];
      ist_set_a: assert property ((ev[i] && act_f[i].irq_en) |=> st_reg.ist[i])
         else $error("enabled event did not flag");
      ist_keep_a: assert property ((st_reg.ist[i] && !w1c) |=> st_reg.ist[i])
         else $error("flag dropped without a clear");
      ist_clear_a: assert property ((w1c && !(ev[i] && act_f[i].irq_en)) |=> !st_reg.ist[i])
         else $error("flag not cleared by write");
      ist_quiet_a: assert property ((!st_reg.ist[i] && !(ev[i] && act_f[i].irq_en))
         |=> !st_reg.ist[i])
         else $error("flag rose without enabled event");
   end

endmodule

// ### tb/udc_field_model.sv
// udc_field_model: proximity sensors, direction level and start/stop switch seen by the counter
// assumes the bench raises a request for one hclk cycle per sensed object and spaces them apart
`timescale 1ns/1ps
module udc_field_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests from the bench
   input wire logic up_req,
   input wire logic dn_req,
   input wire logic dir,
   input wire logic hw_run,
   input wire logic cp_req,
   // to the counter
   output udc_pkg::udc_field_in_type field_out
);
   // one object gives one high cycle; lines idle low so every pass is a fresh rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         field_out <= '0;
      end else begin
         field_out <= {up_req, dn_req, dir, hw_run, cp_req};
      end
   end
endmodule

// ### tb/test_updown_counter_dual_compare.sv
// test_updown_counter_dual_compare: self-checking bench for udc_top
// assumes udc_field_model stands in for the sensors, one ahb-lite master, zero wait states
`timescale 1ns/1ps
`include "udc_map.svh"
module test_updown_counter_dual_compare;
   logic hclk, hresetn, hwrite, hready, hreadyout, hresp, dout_a, dout_b, irq;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic up_req, dn_req, dir, hw_run, cp_req;
   udc_pkg::udc_field_in_type field_in;
   int err_total, compares, cyc;
   logic [35:0] rows [9];
   assign hready = hreadyout;
   udc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .field_in(field_in), .dout_a(dout_a), .dout_b(dout_b), .irq(irq));
   udc_field_model u_field (.hclk(hclk), .hresetn(hresetn), .up_req(up_req), .dn_req(dn_req), .dir(dir),
      .hw_run(hw_run), .cp_req(cp_req), .field_out(field_in));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic print_verdict();
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // master never assumes a latency: it waits on hready both phases
   task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h000000, a};
      hwrite <= wr_n;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk({4'h0, rv}, {4'h0, e});
   endtask
   // three idle edges after the request let the count settle before any read
   task automatic pulse(input logic up);
      up_req <= up;
      dn_req <= ~up;
      @(posedge hclk);
      up_req <= 1'b0;
      dn_req <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
   initial begin
      {hwrite, up_req, dn_req, cp_req, dir, hw_run} = 6'h03;
      hresetn = 1'b0;
      htrans = 2'h0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      // rows: up or down pulse, then count, dout_a, dout_b, irq after it
      rows = '{{1'b1, 32'h1, 3'b000}, {1'b1, 32'h2, 3'b000}, {1'b1, 32'h3, 3'b001},
         {1'b0, 32'h2, 3'b101}, {1'b1, 32'h3, 3'b001}, {1'b0, 32'h2, 3'b101},
         {1'b0, 32'h1, 3'b101}, {1'b0, 32'h0, 3'b111}, {1'b1, 32'h1, 3'b101}};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({33'h0, dout_a, dout_b, irq}, 36'h0);
      chk({34'h0, hresp, hreadyout}, 36'h1);
      rd(`UDC_OFF_CTRL, 32'h00000018);
      rd(8'h30, 32'h00000000);
      wr(`UDC_OFF_NEW_A, 32'h00000003);
      wr(`UDC_OFF_NEW_B, 32'h00000001);
      wr(`UDC_OFF_ACT, 32'h06010205);
      wr(`UDC_OFF_IRQ_MASK, 32'h00000001);
      wr(`UDC_OFF_CTRL, 32'h000000DF);
      for (int i = 0; i < 9; i++) begin
         pulse(rows[i][35]);
         bus(1'b0, `UDC_OFF_COUNT, 32'h00000000);
         chk({rows[i][35], rv, dout_a, dout_b, irq}, rows[i]);
      end
      rd(`UDC_OFF_STATUS, 32'h00000006);
      rd(`UDC_OFF_IRQ_STAT, 32'h00000009);
      wr(`UDC_OFF_IRQ_STAT, 32'h00000001);
      rd(`UDC_OFF_IRQ_STAT, 32'h00000008);
      chk({35'h0, irq}, 36'h0);
      hw_run <= 1'b0;
      pulse(1'b1);
      hw_run <= 1'b1;
      rd(`UDC_OFF_COUNT, 32'h00000001);
      wr(`UDC_OFF_CTRL, 32'h000000D7);
      pulse(1'b1);
      rd(`UDC_OFF_COUNT, 32'h00000001);
      wr(`UDC_OFF_CTRL, 32'h000000DD);
      pulse(1'b1);
      pulse(1'b1);
      chk({35'h0, dout_a}, 36'h1);
      wr(`UDC_OFF_START, 32'h00000010);
      wr(`UDC_OFF_NEW_A, 32'h00000020);
      wr(`UDC_OFF_ACT, 32'h0601021D);
      pulse(1'b0);
      pulse(1'b1);
      rd(`UDC_OFF_COUNT, 32'h00000010);
      rd(`UDC_OFF_CMP_A, 32'h00000020);
      pulse(1'b1);
      wr(`UDC_OFF_CTRL, 32'h000000FD);
      @(posedge hclk);
      rd(`UDC_OFF_COUNT, 32'h00000010);
      wr(`UDC_OFF_START, 32'h00000030);
      wr(`UDC_OFF_CTRL, 32'h000000FD);
      @(posedge hclk);
      rd(`UDC_OFF_COUNT, 32'h00000010);
      cp_req <= 1'b1;
      @(posedge hclk);
      cp_req <= 1'b0;
      repeat (3) @(posedge hclk);
      rd(`UDC_OFF_IMAGE, 32'h00000010);
      dir <= 1'b0;
      pulse(1'b1);
      rd(`UDC_OFF_COUNT, 32'h0000000F);
      pulse(1'b0);
      rd(`UDC_OFF_COUNT, 32'h00000010);
      dir <= 1'b1;
      hresetn <= 1'b0;
      @(posedge hclk);
      chk({33'h0, dout_a, dout_b, irq}, 36'h0);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`UDC_OFF_CTRL, 32'h00000018);
      rd(`UDC_OFF_COUNT, 32'h00000000);
      print_verdict();
   end
   // whole run is under two hundred cycles; the ceiling only cuts a hang
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict();
      end
   end
endmodule
